/* src/gfs_pkg.sv */
// Package for the general fault status flags block
// Function
// - PGA over-range flag bit 8, disconnects aux inputs
// - Main HV undervoltage bit 7, live level
// - Output HV undervoltage bit 6, live level
// - Thermal shutdown bit 5 above 165 C
// - Shutdown clears config and channel control, keep some
// - Shutdown flag sticky until status read
// - Thermal warning bit 4 above 145 C
// - Warning not read-cleared, drops below 135 C
// - GPI summary read-clears, edge flags untouched
// - CRC flag never set when CRC disabled
package gfs_pkg;
	localparam int          STATUS_W     = 24;
	localparam int          CFG_W        = 24;
	localparam int          TEMP_W       = 8;
	localparam int          BIT_PGA_OVR  = 8;
	localparam int          BIT_HV_MAIN  = 7;
	localparam int          BIT_HV_OUT   = 6;
	localparam int          BIT_TH_SHDN  = 5;
	localparam int          BIT_TH_WARN  = 4;
	localparam int          BIT_OVC      = 3;
	localparam int          BIT_CFG_ERR  = 2;
	localparam int          BIT_CRC      = 1;
	localparam int          BIT_GPI      = 0;
	localparam logic [TEMP_W-1:0] TEMP_SHDN_C = 8'hA5;
	localparam logic [TEMP_W-1:0] TEMP_WARN_C = 8'h91;
	localparam logic [TEMP_W-1:0] TEMP_HYST_C = 8'h87;
	// Bits of configuration kept across a thermal shutdown
	localparam logic [CFG_W-1:0] CFG_KEEP_MASK  = 24'h000000;
	localparam logic [CFG_W-1:0] CHAN_KEEP_MASK = 24'h000000;
	localparam logic [STATUS_W-1:0] STATUS_RST = 24'h000000;

	typedef struct packed {
		logic pga_over;
		logic hv_main_low;
		logic hv_out_low;
		logic ovc;
		logic cfg_err;
		logic crc_err;
		logic gpi_edge;
	} gfs_events_t;
endpackage

/* src/gfs_status.sv */
// General fault status flags register with read-clear and shutdown reset
module gfs_status (
	input  wire logic                             ref_clk_in,       // 20 MHz clock
	input  wire logic                             sys_rst_in,       // Sync reset, high
	input  wire logic                             clk_en_in,        // Clock enable
	input  wire gfs_pkg::gfs_events_t             events_in,        // Fault sources
	input  wire logic [gfs_pkg::TEMP_W-1:0]       die_temp_in,      // Die temperature, C
	input  wire logic                             crc_enable_in,    // CRC checking enabled
	input  wire logic                             status_read_in,   // Status read strobe
	input  wire logic                             status_write_in,  // Status write strobe (ignored)
	input  wire logic [gfs_pkg::CFG_W-1:0]        cfg_keep_mask_in, // Config bits kept on shutdown
	input  wire logic [gfs_pkg::CFG_W-1:0]        chan_keep_mask_in,// Channel bits kept on shutdown
	output logic      [gfs_pkg::STATUS_W-1:0]     status_out,       // Read data, registered
	output logic                                  pga_disconnect_out,// Aux PGA inputs disconnected
	output logic                                  shutdown_event_out,// Shutdown rising, one cycle
	output logic      [gfs_pkg::CFG_W-1:0]        cfg_clear_mask_out,// Config bits to zero
	output logic      [gfs_pkg::CFG_W-1:0]        chan_clear_mask_out// Channel bits to zero
);
	logic pga_flag;
	logic shdn_flag;
	logic warn_flag;
	logic ovc_flag;
	logic cfg_flag;
	logic crc_flag;
	logic gpi_flag;
	logic hot_q;
	logic hot;
	logic [gfs_pkg::STATUS_W-1:0] next_status;

	assign hot = die_temp_in > gfs_pkg::TEMP_SHDN_C;

	function automatic logic sticky(input logic cur, input logic set, input logic rd);
		sticky = set | (cur & ~rd);
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Sticky flags: set wins over read clear
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			shdn_flag <= 1'b0;
			crc_flag  <= 1'b0;
			gpi_flag  <= 1'b0;
			cfg_flag  <= 1'b0;
			ovc_flag  <= 1'b0;
			hot_q     <= 1'b0;
		end else if (clk_en_in) begin
			hot_q     <= hot;
			shdn_flag <= sticky(shdn_flag, hot & ~hot_q, status_read_in);
			crc_flag  <= sticky(crc_flag, events_in.crc_err & crc_enable_in, status_read_in);
			gpi_flag  <= sticky(gpi_flag, events_in.gpi_edge, status_read_in);
			cfg_flag  <= sticky(cfg_flag, events_in.cfg_err, status_read_in);
			ovc_flag  <= sticky(ovc_flag, events_in.ovc, status_read_in);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Level flags with hysteresis on the warning
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			warn_flag <= 1'b0;
			pga_flag  <= 1'b0;
		end else if (clk_en_in) begin
			pga_flag <= events_in.pga_over;
			if (die_temp_in > gfs_pkg::TEMP_WARN_C)
				warn_flag <= 1'b1;
			else if (die_temp_in < gfs_pkg::TEMP_HYST_C)
				warn_flag <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Read data captured before clears land
	always_comb begin
		next_status = gfs_pkg::STATUS_RST;
		next_status[gfs_pkg::BIT_PGA_OVR] = pga_flag;
		next_status[gfs_pkg::BIT_HV_MAIN] = events_in.hv_main_low;
		next_status[gfs_pkg::BIT_HV_OUT]  = events_in.hv_out_low;
		next_status[gfs_pkg::BIT_TH_SHDN] = shdn_flag;
		next_status[gfs_pkg::BIT_TH_WARN] = warn_flag;
		next_status[gfs_pkg::BIT_OVC]     = ovc_flag;
		next_status[gfs_pkg::BIT_CFG_ERR] = cfg_flag;
		next_status[gfs_pkg::BIT_CRC]     = crc_flag;
		next_status[gfs_pkg::BIT_GPI]     = gpi_flag;
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			status_out <= gfs_pkg::STATUS_RST;
		else if (clk_en_in && status_read_in)
			status_out <= next_status;
	end

	assign pga_disconnect_out  = pga_flag;
	assign shutdown_event_out  = hot & ~hot_q & clk_en_in & ~sys_rst_in;
	assign cfg_clear_mask_out  = shutdown_event_out ? ~cfg_keep_mask_in : '0;
	assign chan_clear_mask_out = shutdown_event_out ? ~chan_keep_mask_in : '0;

	//////////////////////////////////////////////////////////////////////
	// Checks
	a_shdn_sticky: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && shdn_flag && !status_read_in |=> shdn_flag) else $error("shutdown flag lost");
	a_shdn_set: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		shutdown_event_out |=> shdn_flag) else $error("shutdown not flagged");
	a_crc_gate: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && !crc_flag && !crc_enable_in |=> !crc_flag) else $error("crc flag while off");
	a_warn_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && warn_flag && die_temp_in >= gfs_pkg::TEMP_HYST_C |=> warn_flag)
		else $error("warning dropped early");
	a_warn_set: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && die_temp_in > gfs_pkg::TEMP_WARN_C |=> warn_flag) else $error("warning missed");
	a_rsvd_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		status_out[gfs_pkg::STATUS_W-1:gfs_pkg::BIT_PGA_OVR+1] == '0) else $error("reserved nonzero");
	a_read_data: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && shdn_flag |=> status_out[gfs_pkg::BIT_TH_SHDN])
		else $error("read lost flag");
	a_hv_live: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in |=> status_out[gfs_pkg::BIT_HV_MAIN] == $past(events_in.hv_main_low))
		else $error("hv level wrong");
	a_hvo_live: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in |=> status_out[gfs_pkg::BIT_HV_OUT] == $past(events_in.hv_out_low))
		else $error("hvo level wrong");
	a_gpi_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && !events_in.gpi_edge |=> !gpi_flag) else $error("gpi not cleared");
	a_pga_disc: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && events_in.pga_over |=> pga_disconnect_out) else $error("pga not disconnected");
	a_shdn_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		shutdown_event_out |-> cfg_clear_mask_out == ~cfg_keep_mask_in) else $error("config not cleared");

	c_shutdown: cover property (@(posedge ref_clk_in) shutdown_event_out);
	c_read_clear: cover property (@(posedge ref_clk_in) shdn_flag && status_read_in ##1 !shdn_flag);
	c_warn_cycle: cover property (@(posedge ref_clk_in) warn_flag ##[1:50] !warn_flag);
	c_set_on_read: cover property (@(posedge ref_clk_in) status_read_in && events_in.gpi_edge);
	c_pga_disc: cover property (@(posedge ref_clk_in) pga_disconnect_out);

	//////////////////////////////////////////////////////////////////////
	// Read data register, reset values and clock-enable freeze
	a_status_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!(clk_en_in && status_read_in) |=> $stable(status_out))
		else $error("status changed without read");
	a_write_ignored: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		status_write_in && !(clk_en_in && status_read_in) |=> $stable(status_out))
		else $error("write altered status");
	a_reset_zero: assert property (@(posedge ref_clk_in)
		sys_rst_in |=> status_out == '0 && !shdn_flag && !warn_flag && !pga_flag)
		else $error("flags not zero after reset");
	a_freeze_state: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!clk_en_in |=> $stable(shdn_flag) && $stable(warn_flag) && $stable(crc_flag))
		else $error("state moved while disabled");

	//////////////////////////////////////////////////////////////////////
	// Over-range flag
	a_pga_drop: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && !events_in.pga_over |=> !pga_disconnect_out)
		else $error("pga stays disconnected");
	a_pga_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in |=> status_out[gfs_pkg::BIT_PGA_OVR] == $past(pga_flag))
		else $error("pga read wrong");

	//////////////////////////////////////////////////////////////////////
	// Thermal shutdown and warning
	a_shdn_once: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		shutdown_event_out |=> !shutdown_event_out)
		else $error("shutdown pulse too long");
	a_shdn_hot: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		shutdown_event_out |-> die_temp_in > gfs_pkg::TEMP_SHDN_C)
		else $error("shutdown while cool");
	a_shdn_rdclr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && !shutdown_event_out |=> !shdn_flag)
		else $error("shutdown not read cleared");
	a_chan_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		shutdown_event_out |-> chan_clear_mask_out == ~chan_keep_mask_in)
		else $error("channel not cleared");
	a_mask_idle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!shutdown_event_out |-> cfg_clear_mask_out == '0 && chan_clear_mask_out == '0)
		else $error("clear mask without shutdown");
	a_warn_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && die_temp_in < gfs_pkg::TEMP_HYST_C |=> !warn_flag)
		else $error("warning not dropped");
	a_warn_no_rdclr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && warn_flag && die_temp_in >= gfs_pkg::TEMP_HYST_C |=> warn_flag)
		else $error("warning read cleared");
	a_warn_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && warn_flag |=> status_out[gfs_pkg::BIT_TH_WARN])
		else $error("warning not reported");

	//////////////////////////////////////////////////////////////////////
	// Read-clear summary flags
	a_crc_set: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && events_in.crc_err && crc_enable_in |=> crc_flag)
		else $error("crc error missed");
	a_crc_rdclr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && !(events_in.crc_err && crc_enable_in) |=> !crc_flag)
		else $error("crc not read cleared");
	a_crc_off_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && !crc_flag |=> !status_out[gfs_pkg::BIT_CRC])
		else $error("crc reported while clear");
	a_gpi_set: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && events_in.gpi_edge |=> gpi_flag)
		else $error("gpi edge missed");
	a_gpi_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && gpi_flag |=> status_out[gfs_pkg::BIT_GPI])
		else $error("gpi not reported");
	a_ovc_set: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && events_in.ovc |=> ovc_flag)
		else $error("overcurrent missed");
	a_ovc_rdclr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && !events_in.ovc |=> !ovc_flag)
		else $error("overcurrent not read cleared");
	a_cfg_set: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && events_in.cfg_err |=> cfg_flag)
		else $error("config error missed");
	a_cfg_rdclr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && status_read_in && !events_in.cfg_err |=> !cfg_flag)
		else $error("config error not read cleared");
endmodule

/* tb/gfs_status_tb.sv */
// Self-checking bench for the general fault status flags register
module general_fault_status_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk = 0, rst = 1, en = 1, rd = 0, wr = 0, crc_en = 0, rd_q = 0, ot_q = 0;
	logic                 pgad, shev, pga_m, shd_m, warn_m;
	logic [3:0]           stk_m;
	gfs_pkg::gfs_events_t ev = '0;
	logic [7:0]           temp = 8'h19;
	logic [23:0]          keep_c = '0, keep_h = '0, st, cclr, hclr;
	logic [23:0]          q[$];
	logic [7:0]           tbl[8] = '{8'h19, 8'h8C, 8'h86, 8'h87, 8'h92, 8'h91, 8'hA5, 8'hA6};
	int                   mismatches = 0, n_tests = 0, seed = 10427, cyc = 0;
	gfs_status i_gfs_status (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en), .events_in(ev),
		.die_temp_in(temp), .crc_enable_in(crc_en), .status_read_in(rd), .status_write_in(wr),
		.cfg_keep_mask_in(keep_c), .chan_keep_mask_in(keep_h), .status_out(st), .pga_disconnect_out(pgad),
		.shutdown_event_out(shev), .cfg_clear_mask_out(cclr), .chan_clear_mask_out(hclr));
	initial forever #25 clk = ~clk;
	task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Reference flags, noted per read in the queue
	wire sh_rise = temp > 8'hA5 && !ot_q;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rd_q <= rd && en && !rst;
		if (rst) begin
			{pga_m, shd_m, warn_m, stk_m, ot_q} <= '0;
		end else if (en) begin
			pga_m <= ev.pga_over;
			ot_q <= temp > 8'hA5;
			shd_m <= sh_rise || (shd_m && !rd);
			warn_m <= temp > 8'h91 || (warn_m && temp >= 8'h87);
			stk_m <= {ev.ovc, ev.cfg_err, ev.crc_err && crc_en, ev.gpi_edge} | (rd ? 4'h0 : stk_m);
			if (rd) q.push_back({15'h0, pga_m, ev.hv_main_low, ev.hv_out_low, shd_m, warn_m, stk_m});
		end
	end
	////////////////////////////////////////////////////////////////
	// Output watcher
	always @(negedge clk) begin
		if (rd_q) check("status", st, q.pop_front());
		check("disconnect", {23'h0, pgad}, {23'h0, pga_m});
		if (en && !rst) begin
			check("cfg clear", cclr, sh_rise ? ~keep_c : 24'h0);
			check("chan clear", hclr, sh_rise ? ~keep_h : 24'h0);
		end
		if (cyc > 3000) begin
			mismatches++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	// Random traffic; events may land on a read, set wins
	initial begin
		repeat (2) @(posedge clk);
		#5 rst = 0;
		repeat (1500) begin
			@(posedge clk);
			#5 rd = ($random(seed) % 3) == 0;
			en = ($random(seed) % 8) != 0;
			wr = 1'($random(seed));
			crc_en = 1'($random(seed));
			keep_c = 24'($random(seed));
			keep_h = 24'($random(seed));
			ev = 7'($random(seed) & $random(seed));
			if (!rd && ($random(seed) % 6) == 0) temp = tbl[3'($random(seed))];
		end
		rd = 0;
		repeat (3) @(posedge clk);
		stop_test();
	end
endmodule
